// File: process_alarm_logic.sv
// Purpose: two alarm units, loop-break timer and output routing
// Assumes: inputs synchronous to ref_clk_i at 50 MHz
// Notes:   pid_drive_i comes from the regulator outside this block
`timescale 1ns/1ns
`include "alarm_map.svh"
// How it works
// - two alarm units, routable to any output
// - each output carries exactly one selected source
// - zero proportional band selects on/off control
// - off function never asserts an alarm
// - absolute low: value below alarm setpoint
// - absolute high: value above alarm setpoint
// - differential setpoint is deviation from control setpoint
// - sensor break follows front end fault
// - both units share functions, own setpoints
// - high, band, deviation high also trip on fault
// - initial blocking hides alarm present at power-up
// - blocked alarm arms after condition seen false
// - sensor break ignores initial blocking
// - loop break when value idle too long
module process_alarm_logic #(
   parameter int W         = 16,                         // process value width
   parameter int N_OUT     = 4,                          // output channels
   parameter longint unsigned MINUTE_CYCLES = `CYCLES_PER_MINUTE // cycles per minute
) (
   input  wire logic                       ref_clk_i,          // system clock
   input  wire logic                       nrst_i,             // async reset, low
   input  wire logic                       ce_i,               // clock enable
   input  wire logic signed [W-1:0]        process_value_i,    // measured value
   input  wire logic                       sensor_fault_i,     // front end fault
   input  wire logic signed [W-1:0]        control_setpoint_i, // control target
   input  wire logic signed [W-1:0]        alarm_one_setpoint_i,
   input  wire logic signed [W-1:0]        alarm_two_setpoint_i,
   input  wire alarm_pkg::alarm_fn_t       alarm_one_fn_i,
   input  wire alarm_pkg::alarm_fn_t       alarm_two_fn_i,
   input  wire logic                       alarm_one_block_i,  // initial blocking
   input  wire logic                       alarm_two_block_i,
   input  wire logic [15:0]                proportional_band_i,
   input  wire logic                       pid_drive_i,        // regulator pulse
   input  wire logic [7:0]                 loop_break_interval_i, // minutes, 0 off
   input  wire alarm_pkg::out_src_t [N_OUT-1:0] out_src_i,     // source per channel
   output logic [N_OUT-1:0]                out_o,              // channel levels
   output logic                            alarm_one_o,
   output logic                            alarm_two_o,
   output logic                            loop_break_event_o,
   output logic                            on_off_mode_o       // 1 = on/off control
);
   import alarm_pkg::*;
   typedef struct packed {
      logic [N_OUT-1:0] out;
      logic             ctrl;      // control output level
      logic             loop_break_event;       // loop-break latched
      logic [63:0]      tick;      // cycles within a minute
      logic [7:0]       minutes;   // minutes without reaction
      logic signed [W-1:0] pv_ref; // value when timing started
      logic             onoff;
   } st_t;
   st_t st_r, st_nxt;
   logic a1, a2;

   ////////////////////////////////////////////////////////////
   // alarm units, same function set, own setpoint
   alarm_unit #(.W(W)) u_alarm_one (
      .ref_clk_i          (ref_clk_i),
      .nrst_i             (nrst_i),
      .ce_i               (ce_i),
      .function_i         (alarm_one_fn_i),
      .block_en_i         (alarm_one_block_i),
      .process_value_i    (process_value_i),
      .control_setpoint_i (control_setpoint_i),
      .setpoint_i         (alarm_one_setpoint_i),
      .sensor_fault_i     (sensor_fault_i),
      .alarm_o            (a1)
   );
   alarm_unit #(.W(W)) u_alarm_two (
      .ref_clk_i          (ref_clk_i),
      .nrst_i             (nrst_i),
      .ce_i               (ce_i),
      .function_i         (alarm_two_fn_i),
      .block_en_i         (alarm_two_block_i),
      .process_value_i    (process_value_i),
      .control_setpoint_i (control_setpoint_i),
      .setpoint_i         (alarm_two_setpoint_i),
      .sensor_fault_i     (sensor_fault_i),
      .alarm_o            (a2)
   );

   ////////////////////////////////////////////////////////////
   // control, loop-break timer and routing
   always_comb begin
      st_nxt = st_r;
      // on/off: heat while below target; else follow the regulator
      st_nxt.onoff = proportional_band_i == `PB_ZERO;
      st_nxt.ctrl  = st_nxt.onoff ? (process_value_i < control_setpoint_i) : pid_drive_i;
      // loop break: output driving but value unchanged for the interval
      if (loop_break_interval_i == 8'h00) begin
         st_nxt.loop_break_event     = 1'b0;
         st_nxt.tick    = '0;
         st_nxt.minutes = '0;
         st_nxt.pv_ref  = process_value_i;
      end else if (!st_r.ctrl || process_value_i != st_r.pv_ref) begin
         // the value reacted or output idle: restart timing
         st_nxt.loop_break_event     = 1'b0;
         st_nxt.tick    = '0;
         st_nxt.minutes = '0;
         st_nxt.pv_ref  = process_value_i;
      end else if (st_r.tick == 64'(MINUTE_CYCLES - 1)) begin
         st_nxt.tick = '0;
         if (st_r.minutes != 8'hff) begin
            st_nxt.minutes = st_r.minutes + 8'h01;
         end
         if (st_r.minutes + 8'h01 >= loop_break_interval_i) begin
            st_nxt.loop_break_event = 1'b1;
         end
      end else begin
         st_nxt.tick = st_r.tick + 64'h1;
      end
      // routing: one source per channel
      for (int i = 0; i < N_OUT; i++) begin
         unique case (out_src_i[i])
            SRC_CONTROL:      st_nxt.out[i] = st_r.ctrl;
            SRC_ALARM_ONE:    st_nxt.out[i] = a1;
            SRC_ALARM_TWO:    st_nxt.out[i] = a2;
            SRC_ALARM_EITHER: st_nxt.out[i] = a1 | a2;
            SRC_LOOP_BREAK:   st_nxt.out[i] = st_r.loop_break_event;
            default:          st_nxt.out[i] = 1'b0;
         endcase
      end
   end

   // state register, frozen while ce_i is low
   always_ff @(posedge ref_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         st_r <= '0;
      end else if (ce_i) begin
         st_r <= st_nxt;
      end
   end

   assign out_o              = st_r.out;
   assign alarm_one_o        = a1;
   assign alarm_two_o        = a2;
   assign loop_break_event_o = st_r.loop_break_event;
   assign on_off_mode_o      = st_r.onoff;
endmodule

// File: alarm_map.svh
// Purpose: constants of the process alarm logic
// Assumes: process values are signed tenths of a degree
// Notes:   definitions only
`ifndef ALARM_MAP_SVH
`define ALARM_MAP_SVH
`define CLK_PERIOD_NS      20
`define MINUTE_NS          64'd60000000000
// cycles in one minute of loop-break timing
`define CYCLES_PER_MINUTE  (`MINUTE_NS / `CLK_PERIOD_NS)
`define PB_ZERO            16'h0000
`endif

// File: alarm_pkg.sv
// Purpose: types of the process alarm logic
// Assumes: nothing
// Notes:   codes of functions and output sources
package alarm_pkg;
   typedef enum logic [2:0] {
      FN_OFF, FN_ABSOLUTE_LOW, FN_ABSOLUTE_HIGH, FN_DEVIATION,
      FN_DEVIATION_LOW, FN_DEVIATION_HIGH, FN_SENSOR_BREAK
   } alarm_fn_t;
   typedef enum logic [2:0] {
      SRC_CONTROL, SRC_ALARM_ONE, SRC_ALARM_TWO, SRC_ALARM_EITHER, SRC_LOOP_BREAK
   } out_src_t;
endpackage

// File: alarm_unit.sv
// Purpose: one alarm unit with comparison and initial blocking
// Assumes: inputs synchronous to ref_clk_i
// Notes:   alarm_o is registered
`timescale 1ns/1ns
`include "alarm_map.svh"
module alarm_unit #(
   parameter int W = 16                              // process value width
) (
   input  wire logic                ref_clk_i,       // system clock
   input  wire logic                nrst_i,          // async reset, low
   input  wire logic                ce_i,            // clock enable
   input  wire alarm_pkg::alarm_fn_t function_i,     // selected function
   input  wire logic                block_en_i,      // initial blocking enable
   input  wire logic signed [W-1:0] process_value_i, // measured value
   input  wire logic signed [W-1:0] control_setpoint_i,
   input  wire logic signed [W-1:0] setpoint_i,      // threshold or deviation
   input  wire logic                sensor_fault_i,  // front end fault flag
   output logic                     alarm_o          // alarm result
);
   import alarm_pkg::*;
   typedef struct packed {
      logic armed;   // blocking released
      logic alarm;   // registered result
   } st_t;
   st_t st_r, st_nxt;
   logic signed [W:0] lo_lim, hi_lim, pv;
   logic cond;

   ////////////////////////////////////////////////////////////
   // condition and blocking
   always_comb begin
      // sign-extended to the width of the limits so signed compares stay exact
      pv     = (W+1)'(process_value_i);
      // widened by one bit so setpoint +/- deviation cannot wrap
      lo_lim = (W+1)'(control_setpoint_i) - (W+1)'(setpoint_i);
      hi_lim = (W+1)'(control_setpoint_i) + (W+1)'(setpoint_i);
      cond   = 1'b0;
      unique case (function_i)
         FN_OFF:            cond = 1'b0;
         FN_ABSOLUTE_LOW:   cond = process_value_i < setpoint_i;
         FN_ABSOLUTE_HIGH:  cond = process_value_i > setpoint_i || sensor_fault_i;
         FN_DEVIATION:      cond = pv < lo_lim || pv > hi_lim || sensor_fault_i;
         FN_DEVIATION_LOW:  cond = pv < lo_lim;
         FN_DEVIATION_HIGH: cond = pv > hi_lim || sensor_fault_i;
         FN_SENSOR_BREAK:   cond = sensor_fault_i;
         default:           cond = 1'b0;
      endcase
      st_nxt = st_r;
      // arm once the condition has been seen false
      if (!cond) begin
         st_nxt.armed = 1'b1;
      end
      if (function_i == FN_SENSOR_BREAK || !block_en_i) begin
         st_nxt.alarm = cond;
      end else begin
         st_nxt.alarm = cond && st_r.armed;
      end
   end

   // state register, frozen while ce_i is low
   always_ff @(posedge ref_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         st_r <= '0;
      end else if (ce_i) begin
         st_r <= st_nxt;
      end
   end
   assign alarm_o = st_r.alarm;
endmodule

// File: front_end_model.sv
// Purpose: measurement front end feeding the alarm logic
// Assumes: the bench sets the true temperature
// Notes:   a broken sensor reports junk, never a clean reading
`timescale 1ns/1ns
module front_end_model (
   input  wire logic signed [15:0] temp_i,  // true temperature
   input  wire logic               open_i,  // sensor wire broken
   output logic signed [15:0]      pv_o,    // reported value
   output logic                    fault_o  // fault flag
);
   // inverted value so a stuck reading cannot pass for a real one
   assign pv_o    = open_i ? ~temp_i : temp_i;
   assign fault_o = open_i;
endmodule

// File: process_alarm_checker.sv
// Purpose: port assertions of the alarm logic
// Assumes: one clock domain
// Notes:   unit one stands for both units
`timescale 1ns/1ns
module process_alarm_checker (
   input wire logic                   ref_clk_i,
   input wire logic                   nrst_i,
   input wire logic                   ce_i,
   input wire logic signed [15:0]     process_value_i,
   input wire logic                   sensor_fault_i,
   input wire logic signed [15:0]     control_setpoint_i,
   input wire logic signed [15:0]     alarm_one_setpoint_i,
   input wire alarm_pkg::alarm_fn_t   alarm_one_fn_i,
   input wire logic                   alarm_one_block_i,
   input wire logic [15:0]            proportional_band_i,
   input wire alarm_pkg::out_src_t [3:0] out_src_i,
   input wire logic [3:0]             out_o,
   input wire logic                   alarm_one_o,
   input wire logic                   on_off_mode_o
);
   import alarm_pkg::*;
   logic               ok;  // enabled edge out of reset
   logic signed [17:0] lo;  // widened so limits never wrap
   logic signed [17:0] hi;
   assign ok = ce_i && nrst_i;
   assign lo = control_setpoint_i - alarm_one_setpoint_i;
   assign hi = control_setpoint_i + alarm_one_setpoint_i;
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!nrst_i);
   ////////////////////////////////////////
   chk_off_silent: assert property ($past(ok && alarm_one_fn_i == FN_OFF) |-> !alarm_one_o)
      else $error("alarm raised while off");
   chk_high_trip: assert property ($past(ok && alarm_one_fn_i == FN_ABSOLUTE_HIGH && !alarm_one_block_i
      && (sensor_fault_i || process_value_i > alarm_one_setpoint_i)) |-> alarm_one_o) else $error("high missed");
   chk_dev_low: assert property ($past(ok && alarm_one_fn_i == FN_DEVIATION_LOW && !alarm_one_block_i
      && !sensor_fault_i) |-> alarm_one_o == $past(process_value_i < lo)) else $error("deviation low wrong");
   chk_dev_high: assert property ($past(ok && alarm_one_fn_i == FN_DEVIATION_HIGH && !alarm_one_block_i)
      |-> alarm_one_o == $past(sensor_fault_i || process_value_i > hi)) else $error("deviation high wrong");
   chk_band_out: assert property ($past(ok && alarm_one_fn_i == FN_DEVIATION && !alarm_one_block_i) |->
      alarm_one_o == $past(sensor_fault_i || process_value_i < lo || process_value_i > hi)) else $error("band wrong");
   chk_break_fault: assert property ($past(ok && alarm_one_fn_i == FN_SENSOR_BREAK) |->
      alarm_one_o == $past(sensor_fault_i)) else $error("sensor break wrong");
   chk_route_one: assert property ($past(ok && out_src_i[0] == SRC_ALARM_ONE) |->
      out_o[0] == $past(alarm_one_o)) else $error("routing wrong");
   chk_on_off: assert property ($past(ok) |->
      on_off_mode_o == ($past(proportional_band_i) == 16'h0000)) else $error("control mode wrong");
   cover property (alarm_one_o && out_o[0]);
   cover property ($rose(alarm_one_o) && alarm_one_block_i);
   cover property (on_off_mode_o && out_o[3]);
endmodule
bind process_alarm_logic process_alarm_checker i_chk (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .ce_i(ce_i),
   .process_value_i(process_value_i), .sensor_fault_i(sensor_fault_i), .control_setpoint_i(control_setpoint_i),
   .alarm_one_setpoint_i(alarm_one_setpoint_i), .alarm_one_fn_i(alarm_one_fn_i), .out_o(out_o),
   .alarm_one_block_i(alarm_one_block_i), .proportional_band_i(proportional_band_i), .out_src_i(out_src_i),
   .alarm_one_o(alarm_one_o), .on_off_mode_o(on_off_mode_o));

// File: testbench.sv
// Purpose: self-checking bench of the alarm logic
// Assumes: minute shortened to 10 cycles
// Notes:   blocking first, then rows, control, loop break, enable and reset
`timescale 1ns/1ns
module testbench;
   import alarm_pkg::*;
   typedef struct {alarm_fn_t f; logic [15:0] p, s1, s2; logic x, a1, a2;} row_t;
   logic              clk = 0, nrst = 0, ce = 1, brk = 1, flt, b1 = 1, b2 = 1, pid = 0, a1, a2, loop_break_event, onoff;
   logic signed [15:0] temp = 0, pv, csp = 16'h01f4, sp1 = 16'h0064, sp2 = 0;
   logic [15:0]       band = 0;   // zero band: on/off control
   logic [7:0]        lbi = 0;    // loop-break minutes
   logic [3:0]        out;
   alarm_fn_t         fn1 = FN_ABSOLUTE_LOW, fn2 = FN_SENSOR_BREAK;
   out_src_t [3:0]    src = '{SRC_CONTROL, SRC_ALARM_EITHER, SRC_ALARM_TWO, SRC_ALARM_ONE};
   int                error_cnt = 0, samples_checked = 0, n;
   // csp 500: deviation 50 gives limits 450 and 550
   row_t rows [9] = '{'{FN_OFF, 16'h0000, 16'h0064, 16'h0064, 1, 0, 0},
      '{FN_ABSOLUTE_LOW, 16'h0064, 16'h0065, 16'h0064, 0, 1, 0}, '{FN_ABSOLUTE_HIGH, 16'h0064, 16'h0063, 16'h0064, 0, 1, 0},
      '{FN_ABSOLUTE_HIGH, 16'h0064, 16'h7000, 16'h7000, 1, 1, 1}, '{FN_DEVIATION_LOW, 16'h01c1, 16'h0032, 16'h0033, 0, 1, 0},
      '{FN_DEVIATION_HIGH, 16'h0227, 16'h0032, 16'h0033, 0, 1, 0}, '{FN_DEVIATION, 16'h0227, 16'h0032, 16'h0064, 0, 1, 0},
      '{FN_SENSOR_BREAK, 16'h01f4, 16'h0000, 16'h0000, 1, 1, 1}, '{FN_SENSOR_BREAK, 16'h01f4, 16'h0000, 16'h0000, 0, 0, 0}};
   always #10 clk = ~clk;
   front_end_model i_fe (.temp_i(temp), .open_i(brk), .pv_o(pv), .fault_o(flt));
   process_alarm_logic #(.MINUTE_CYCLES(10)) i_dut (.ref_clk_i(clk), .nrst_i(nrst), .ce_i(ce), .process_value_i(pv),
      .sensor_fault_i(flt), .control_setpoint_i(csp), .alarm_one_setpoint_i(sp1), .alarm_two_setpoint_i(sp2),
      .alarm_one_fn_i(fn1), .alarm_two_fn_i(fn2), .alarm_one_block_i(b1), .alarm_two_block_i(b2),
      .proportional_band_i(band), .pid_drive_i(pid), .loop_break_interval_i(lbi), .out_src_i(src), .out_o(out),
      .alarm_one_o(a1), .alarm_two_o(a2), .loop_break_event_o(loop_break_event), .on_off_mode_o(onoff));
   ////////////////////////////////////////
   task chk(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task cyc(input int k);
      repeat (k) @(negedge clk);
   endtask
   task print_verdict;
      $display("checked %0d, mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   // power-up with both alarms already in condition
   initial begin
      cyc(20);
      chk(out, 4'h0);
      nrst = 1;
      cyc(3);
      chk(a1, 1'b0);
      chk(a2, 1'b1);
      temp = 16'h00c8;
      brk = 0;
      cyc(2);
      chk(a1, 1'b0);
      temp = 16'h0000;
      cyc(2);
      chk(a1, 1'b1);
      b1 = 0;
      b2 = 0;
      $display("blocking test done");
      foreach (rows[i]) begin
         {fn1, fn2, temp, sp1, sp2, brk} = {rows[i].f, rows[i].f, rows[i].p, rows[i].s1, rows[i].s2, rows[i].x};
         cyc(2);
         chk(a1, rows[i].a1);
         chk(a2, rows[i].a2);
         chk(out[2:0], {rows[i].a1 | rows[i].a2, rows[i].a2, rows[i].a1});
      end
      $display("function rows done");
      temp = 16'h0100;
      cyc(2);
      chk({onoff, out[3]}, 2'b11);
      band = 16'h000a;
      cyc(2);
      chk({onoff, out[3]}, 2'b00);
      pid = 1;
      cyc(2);
      chk(out[3], 1'b1);
      $display("control test done");
      {lbi, src[3], temp} = {8'h02, SRC_LOOP_BREAK, 16'h0101};
      cyc(12);
      chk(loop_break_event, 1'b0);
      n = 0;
      while (loop_break_event !== 1'b1 && n < 30) begin
         cyc(1);
         n++;
      end
      // a wait that runs out of its bound counts as a mismatch
      if (n >= 30) begin
         error_cnt++;
      end
      cyc(2);
      chk({loop_break_event, out[3]}, 2'b11);
      {lbi, temp} = {8'h00, 16'h0102};
      cyc(30);
      chk(loop_break_event, 1'b0);
      $display("loop break test done");
      // clock enable low: a new fault must not reach the frozen alarm
      ce = 0;
      brk = 1;
      cyc(3);
      chk(a1, 1'b0);
      ce = 1;
      cyc(2);
      chk(a1, 1'b1);
      // reset in mid-run clears every output flop
      nrst = 0;
      cyc(1);
      chk({a1, a2, out}, 6'h00);
      nrst = 1;
      cyc(2);
      chk(a2, 1'b1);
      brk = 0;
      cyc(2);
      chk(a2, 1'b0);
      $display("enable and reset test done");
      print_verdict;
   end
endmodule
